/* File: srb_defines.svh */
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

// Word layout shared by every request bank
`define SRB_DATA_W        32
`define SRB_REQ_W         16
`define SRB_MASK_LSB      16
`define SRB_MASK_MSB      31
`define SRB_REQ_MSB       15
`define SRB_NUM_BANKS     7
`define SRB_ADDR_W        12
`define SRB_MIN_ADDR_W    9

// Byte offsets of the request banks
`define SRB_OFF_BANK2     12'h1c0
`define SRB_OFF_BANK3     12'h1c4
`define SRB_OFF_BANK4     12'h1c8
`define SRB_OFF_BANK5     12'h1cc
`define SRB_OFF_BANK6     12'h1d0
`define SRB_OFF_BANK7     12'h1d4
`define SRB_OFF_BANK8     12'h1d8

// Reset value of every request and mask bit
`define SRB_REQ_RESET     16'h0000
`define SRB_RDATA_RESET   32'h0000_0000
`define SRB_HI_ZERO       16'h0000

// Writable bits of each bank; zeros are reserved and read zero
`define SRB_WMASK_BANK2   16'hfdff
`define SRB_WMASK_BANK3   16'hdfff
`define SRB_WMASK_BANK4   16'h71ad
`define SRB_WMASK_BANK5   16'h07b9
`define SRB_WMASK_BANK6   16'hffff
`define SRB_WMASK_BANK7   16'h33ff
`define SRB_WMASK_BANK8   16'h7fff

// Positions of individually named request bits
`define SRB_POS_TWOWIRE5  15
`define SRB_POS_TWOWIRE0  10
`define SRB_POS_IOPORT8   8
`define SRB_POS_IOPORT0   0
`define SRB_POS_FLASH1    14
`define SRB_POS_FLASH0    13
`define SRB_POS_PWM2      5
`define SRB_POS_DMA2      0
`define SRB_POS_SPI2      5
`define SRB_POS_VIO1NIU   7

`endif

/* File: srb_pkg.sv */
package srb_pkg;
    typedef logic [15:0] srb_req_t;
    typedef logic [31:0] srb_word_t;
    typedef logic [6:0]  srb_hit_t;
    typedef enum {
        SRB_BANK2,
        SRB_BANK3,
        SRB_BANK4,
        SRB_BANK5,
        SRB_BANK6,
        SRB_BANK7,
        SRB_BANK8
    } srb_bank_e;
endpackage : srb_pkg

/* File: srb_req_slice.sv */
`include "srb_defines.svh"

module srb_req_slice #(
    parameter srb_pkg::srb_req_t WMASK = 16'hffff
) (
    input wire logic clk,
    input wire logic rst_n,
    srb_slice_if.bank bus
);

    ////////////////////////////////////////////////////////////////////////////
    // Masked update; reserved positions can never be set
    srb_pkg::srb_req_t q_q;
    srb_pkg::srb_req_t q_d;
    srb_pkg::srb_req_t wmask_bits;

    assign wmask_bits = bus.wdata[`SRB_MASK_MSB:`SRB_MASK_LSB] & WMASK;
    assign q_d        = (q_q & ~wmask_bits)
                      | (bus.wdata[`SRB_REQ_MSB:0] & wmask_bits);

    // Request bits; mask half is never stored, so it cannot read back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= `SRB_REQ_RESET;
        end else if (bus.wr_en) begin
            q_q <= q_d;
        end
    end

    assign bus.q = q_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the masked update
    property p_masked_keep;
        @(posedge clk) disable iff (!rst_n)
        bus.wr_en |=> ((q_q & ~$past(bus.wdata[31:16]))
                      == ($past(q_q) & ~$past(bus.wdata[31:16])));
    endproperty
    a_masked_keep: assert property (p_masked_keep)
        else $error("unmasked request bit changed on write");

    property p_masked_load;
        @(posedge clk) disable iff (!rst_n)
        bus.wr_en |=> ((q_q & $past(bus.wdata[31:16]))
                      == ($past(bus.wdata[15:0]) & $past(bus.wdata[31:16]) & WMASK));
    endproperty
    a_masked_load: assert property (p_masked_load)
        else $error("masked request bit did not take written value");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        (q_q & ~WMASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved request bit is set");

    property p_idle_hold;
        @(posedge clk) disable iff (!rst_n)
        !bus.wr_en |=> $stable(q_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("request bits changed without a write");

endmodule : srb_req_slice

/* File: srb_slice_if.sv */
interface srb_slice_if;
    logic              wr_en;
    srb_pkg::srb_word_t wdata;
    srb_pkg::srb_req_t  q;
    modport ctrl (output wr_en, output wdata, input q);
    modport bank (input wr_en, input wdata, output q);
endinterface : srb_slice_if

/* File: srb_top.sv */
// Our own choice: the APB register port.
`include "srb_defines.svh"

module srb_top #(
    parameter int ADDR_W = `SRB_ADDR_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [15:0]       reset_req_bank2,
    output logic      [15:0]       reset_req_bank3,
    output logic      [15:0]       reset_req_bank4,
    output logic      [15:0]       reset_req_bank5,
    output logic      [15:0]       reset_req_bank6,
    output logic      [15:0]       reset_req_bank7,
    output logic      [15:0]       reset_req_bank8,
    output logic                   twowire_port5_reset_req,
    output logic                   twowire_port0_reset_req,
    output logic                   io_port8_reset_req,
    output logic                   io_port0_reset_req,
    output logic                   flash_ctrl1_reset_req,
    output logic                   flash_ctrl0_reset_req,
    output logic                   secondary_pulse_width_reset_req,
    output logic                   second_dma_reset_req,
    output logic                   serial_port2_reset_req,
    output logic                   video1_netunit_axi_reset_req
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Top offset needs nine address bits; narrower buses cannot reach the map
    if (ADDR_W < `SRB_MIN_ADDR_W) begin : g_bad_addr_w
        $error("address width too narrow for the request bank map");
    end
    if (`SRB_NUM_BANKS != 7) begin : g_bad_banks
        $error("bank table and bank count disagree");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Offset of each bank by index
    function automatic logic [11:0] srb_offset(input srb_pkg::srb_bank_e b);
        case (b)
            srb_pkg::SRB_BANK2: srb_offset = `SRB_OFF_BANK2;
            srb_pkg::SRB_BANK3: srb_offset = `SRB_OFF_BANK3;
            srb_pkg::SRB_BANK4: srb_offset = `SRB_OFF_BANK4;
            srb_pkg::SRB_BANK5: srb_offset = `SRB_OFF_BANK5;
            srb_pkg::SRB_BANK6: srb_offset = `SRB_OFF_BANK6;
            srb_pkg::SRB_BANK7: srb_offset = `SRB_OFF_BANK7;
            srb_pkg::SRB_BANK8: srb_offset = `SRB_OFF_BANK8;
            default:            srb_offset = `SRB_OFF_BANK2;
        endcase
    endfunction : srb_offset

    // Writable bits of each bank; holes are the reserved positions
    function automatic srb_pkg::srb_req_t srb_wmask(input srb_pkg::srb_bank_e b);
        case (b)
            srb_pkg::SRB_BANK2: srb_wmask = `SRB_WMASK_BANK2;
            srb_pkg::SRB_BANK3: srb_wmask = `SRB_WMASK_BANK3;
            srb_pkg::SRB_BANK4: srb_wmask = `SRB_WMASK_BANK4;
            srb_pkg::SRB_BANK5: srb_wmask = `SRB_WMASK_BANK5;
            srb_pkg::SRB_BANK6: srb_wmask = `SRB_WMASK_BANK6;
            srb_pkg::SRB_BANK7: srb_wmask = `SRB_WMASK_BANK7;
            srb_pkg::SRB_BANK8: srb_wmask = `SRB_WMASK_BANK8;
            default:            srb_wmask = `SRB_REQ_RESET;
        endcase
    endfunction : srb_wmask

    // One-hot bank hit; only whole aligned words decode
    function automatic srb_pkg::srb_hit_t srb_decode(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        srb_decode = '0;
        wide       = 32'(a);
        for (int i = 0; i < `SRB_NUM_BANKS; i++) begin
            srb_decode[i] = (wide == {20'h0_0000, srb_offset(srb_pkg::srb_bank_e'(i))});
        end
    endfunction : srb_decode

    // Read selection across the banks
    function automatic srb_pkg::srb_req_t srb_select(input srb_pkg::srb_hit_t h,
                                                    input logic [6:0][15:0] q);
        srb_select = `SRB_REQ_RESET;
        for (int i = 0; i < `SRB_NUM_BANKS; i++) begin
            srb_select = srb_select | (q[i] & {16{h[i]}});
        end
    endfunction : srb_select

    ////////////////////////////////////////////////////////////////////////////
    // APB phase decode
    wire                    setup_ph;
    wire                    access_ph;
    wire                    wr_access;
    wire srb_pkg::srb_hit_t hit;
    wire                    mapped;
    wire [6:0][15:0]        bank_q;
    wire srb_pkg::srb_req_t rd_sel;

    // Zero wait states: every access phase completes at once
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_access = access_ph & pwrite & pready;
    assign hit       = srb_decode(paddr);
    assign mapped    = |hit;
    assign rd_sel    = srb_select(hit, bank_q);
    assign pready    = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Request banks
    // Each bank gets its own slice; a write reaches only the hit bank
    for (genvar i = 0; i < `SRB_NUM_BANKS; i++) begin : g_bank
        srb_slice_if s_if ();

        assign s_if.wr_en = wr_access & hit[i];
        assign s_if.wdata = pwdata;
        assign bank_q[i]  = s_if.q;

        srb_req_slice #(
            .WMASK (srb_wmask(srb_pkg::srb_bank_e'(i)))
        ) u_slice (
            .clk   (pclk),
            .rst_n (presetn),
            .bus   (s_if.bank)
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and error response
    // Captured in the setup cycle so prdata comes from a flop; no other
    // transfer can slip in before the access edge, so it is never stale
    logic [31:0] prdata_q;
    logic        err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `SRB_RDATA_RESET;
            err_q    <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= pwrite ? `SRB_RDATA_RESET : {`SRB_HI_ZERO, rd_sel};
            err_q    <= ~mapped;
        end
    end

    // Mask half reads zero; unmapped words answer with an error
    assign prdata  = prdata_q;
    assign pslverr = access_ph & err_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset request outputs, active high while the bit is one
    assign reset_req_bank2 = bank_q[srb_pkg::SRB_BANK2];
    assign reset_req_bank3 = bank_q[srb_pkg::SRB_BANK3];
    assign reset_req_bank4 = bank_q[srb_pkg::SRB_BANK4];
    assign reset_req_bank5 = bank_q[srb_pkg::SRB_BANK5];
    assign reset_req_bank6 = bank_q[srb_pkg::SRB_BANK6];
    assign reset_req_bank7 = bank_q[srb_pkg::SRB_BANK7];
    assign reset_req_bank8 = bank_q[srb_pkg::SRB_BANK8];

    // Named taps for units wired by name rather than by vector
    assign twowire_port5_reset_req         = reset_req_bank2[`SRB_POS_TWOWIRE5];
    assign twowire_port0_reset_req         = reset_req_bank2[`SRB_POS_TWOWIRE0];
    assign io_port8_reset_req              = reset_req_bank2[`SRB_POS_IOPORT8];
    assign io_port0_reset_req              = reset_req_bank2[`SRB_POS_IOPORT0];
    assign flash_ctrl1_reset_req           = reset_req_bank4[`SRB_POS_FLASH1];
    assign flash_ctrl0_reset_req           = reset_req_bank4[`SRB_POS_FLASH0];
    assign secondary_pulse_width_reset_req = reset_req_bank4[`SRB_POS_PWM2];
    assign second_dma_reset_req            = reset_req_bank4[`SRB_POS_DMA2];
    assign serial_port2_reset_req          = reset_req_bank5[`SRB_POS_SPI2];
    assign video1_netunit_axi_reset_req    = reset_req_bank6[`SRB_POS_VIO1NIU];

    ////////////////////////////////////////////////////////////////////////////
    // Checks at the bus side

    property p_reset_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (bank_q == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("request bits not clear after reset");

    property p_out_follow;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(12'h1c0))
        |=> (reset_req_bank2 == ((($past(reset_req_bank2) & ~$past(pwdata[31:16]))
                                | ($past(pwdata[15:0]) & $past(pwdata[31:16])))
                                & 16'hfdff));
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("bank two output does not follow masked write");

    property p_read_bank2;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == ADDR_W'(12'h1c0))
        ##1 (access_ph && !pwrite) |-> (prdata == {16'h0000, reset_req_bank2});
    endproperty
    a_read_bank2: assert property (p_read_bank2)
        else $error("read of bank two returned wrong data");

    property p_bit9_zero;
        @(posedge pclk) disable iff (!presetn)
        !reset_req_bank2[9];
    endproperty
    a_bit9_zero: assert property (p_bit9_zero)
        else $error("reserved bit nine of bank two set");

    property p_bank4_holes;
        @(posedge pclk) disable iff (!presetn)
        (reset_req_bank4 & 16'h8e52) == 16'h0000;
    endproperty
    a_bank4_holes: assert property (p_bank4_holes)
        else $error("reserved bit of bank four set");

    property p_bank8_nomask;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(12'h1d8) && pwdata[31:16] == 16'h0000)
        |=> $stable(reset_req_bank8);
    endproperty
    a_bank8_nomask: assert property (p_bank8_nomask)
        else $error("bank eight changed under an empty mask");

    // Misaligned words never decode, so they must answer with an error
    property p_err_misaligned;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && paddr[1:0] != 2'b00) ##1 access_ph |-> pslverr;
    endproperty
    a_err_misaligned: assert property (p_err_misaligned)
        else $error("misaligned access answered without an error");

    property p_bank3_ok;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && paddr == ADDR_W'(`SRB_OFF_BANK3)) ##1 access_ph |-> !pslverr;
    endproperty
    a_bank3_ok: assert property (p_bank3_ok)
        else $error("bank three access answered with an error");

    property p_mask_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && !pwrite) |-> (prdata[31:16] == `SRB_HI_ZERO);
    endproperty
    a_mask_reads_zero: assert property (p_mask_reads_zero)
        else $error("write mask half did not read as zero");

    // A refused write must leave every bank alone
    property p_refused_keep;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && pslverr) |=> $stable(bank_q);
    endproperty
    a_refused_keep: assert property (p_refused_keep)
        else $error("refused write changed a request bank");

    // Request bits, named taps among them, follow a masked write one cycle later
    property p_follow_twowire0;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK2) && pwdata[26])
        |=> (twowire_port0_reset_req == $past(pwdata[10]));
    endproperty
    a_follow_twowire0: assert property (p_follow_twowire0)
        else $error("two-wire port zero request did not follow write");

    property p_follow_ioport8;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK2) && pwdata[24])
        |=> (io_port8_reset_req == $past(pwdata[8]));
    endproperty
    a_follow_ioport8: assert property (p_follow_ioport8)
        else $error("io port eight request did not follow write");

    property p_follow_matrix_axi;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK3) && pwdata[25])
        |=> (reset_req_bank3[9] == $past(pwdata[9]));
    endproperty
    a_follow_matrix_axi: assert property (p_follow_matrix_axi)
        else $error("bank three bit nine did not follow write");

    property p_follow_card_arb;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK3) && pwdata[17])
        |=> (reset_req_bank3[1] == $past(pwdata[1]));
    endproperty
    a_follow_card_arb: assert property (p_follow_card_arb)
        else $error("bank three bit one did not follow write");

    property p_follow_flash1;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK4) && pwdata[30])
        |=> (flash_ctrl1_reset_req == $past(pwdata[14]));
    endproperty
    a_follow_flash1: assert property (p_follow_flash1)
        else $error("flash controller one request did not follow write");

    property p_follow_dma2;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK4) && pwdata[16])
        |=> (second_dma_reset_req == $past(pwdata[0]));
    endproperty
    a_follow_dma2: assert property (p_follow_dma2)
        else $error("second dma request did not follow write");

    property p_follow_spi2;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK5) && pwdata[21])
        |=> (serial_port2_reset_req == $past(pwdata[5]));
    endproperty
    a_follow_spi2: assert property (p_follow_spi2)
        else $error("serial port two request did not follow write");

    property p_follow_bank6_top;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK6) && pwdata[31])
        |=> (reset_req_bank6[15] == $past(pwdata[15]));
    endproperty
    a_follow_bank6_top: assert property (p_follow_bank6_top)
        else $error("bank six bit fifteen did not follow write");

    property p_follow_vio1;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK6) && pwdata[23])
        |=> (video1_netunit_axi_reset_req == $past(pwdata[7]));
    endproperty
    a_follow_vio1: assert property (p_follow_vio1)
        else $error("video network unit request did not follow write");

    property p_follow_hdmi;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_W'(`SRB_OFF_BANK7) && pwdata[25])
        |=> (reset_req_bank7[9] == $past(pwdata[9]));
    endproperty
    a_follow_hdmi: assert property (p_follow_hdmi)
        else $error("bank seven bit nine did not follow write");

endmodule : srb_top

/* File: test_soft_reset_request_bank.sv */
module test_soft_reset_request_bank;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] rq [7];
    wire  [9:0]  tap;
    int          error_cnt;
    int          total_checks;
    int          cyc;
    // Bank offsets and writable bits, bank two first; zeros are reserved
    logic [11:0] off [7] = '{12'h1c0, 12'h1c4, 12'h1c8, 12'h1cc, 12'h1d0, 12'h1d4, 12'h1d8};
    logic [15:0] wm  [7] = '{16'hfdff, 16'hdfff, 16'h71ad, 16'h07b9, 16'hffff, 16'h33ff, 16'h7fff};

    srb_top u_dut (
        .pclk                            (pclk),
        .presetn                         (presetn),
        .psel                            (psel),
        .penable                         (penable),
        .pwrite                          (pwrite),
        .paddr                           (paddr),
        .pwdata                          (pwdata),
        .prdata                          (prdata),
        .pready                          (pready),
        .pslverr                         (pslverr),
        .reset_req_bank2                 (rq[0]),
        .reset_req_bank3                 (rq[1]),
        .reset_req_bank4                 (rq[2]),
        .reset_req_bank5                 (rq[3]),
        .reset_req_bank6                 (rq[4]),
        .reset_req_bank7                 (rq[5]),
        .reset_req_bank8                 (rq[6]),
        .twowire_port5_reset_req         (tap[9]),
        .twowire_port0_reset_req         (tap[8]),
        .io_port8_reset_req              (tap[7]),
        .io_port0_reset_req              (tap[6]),
        .flash_ctrl1_reset_req           (tap[5]),
        .flash_ctrl0_reset_req           (tap[4]),
        .secondary_pulse_width_reset_req (tap[3]),
        .second_dma_reset_req            (tap[2]),
        .serial_port2_reset_req          (tap[1]),
        .video1_netunit_axi_reset_req    (tap[0])
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Hang guard: a stuck handshake would otherwise run forever
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One transfer; psel stays up when another setup follows at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic last, output logic [31:0] rd, output logic er);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the rising edge that sees pready high, not before
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (last) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, 1'b1, rd, er);
        chk("write pslverr", {31'h0, err}, {31'h0, er});
    endtask : wr

    // Reads a bank and compares both the read data and its output port
    task automatic rd_chk(input int i, input logic [15:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, off[i], 32'h0000_0000, 1'b1, rd, er);
        chk("read data", {16'h0000, exp}, rd);
        chk("bank port", {16'h0000, exp}, {16'h0000, rq[i]});
        chk("read pslverr", 32'h0000_0000, {31'h0, er});
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values;
        for (int i = 0; i < 7; i++) rd_chk(i, 16'h0000);
        chk("taps", 32'h0000_0000, {22'h0, tap});
    endtask : t_reset_values

    // Back-to-back writes of all ones; reserved holes must stay zero
    task automatic t_all_bits;
        logic [31:0] rd;
        logic        er;
        for (int i = 0; i < 7; i++) apb(1'b1, off[i], 32'hffff_ffff, i == 6, rd, er);
        for (int i = 0; i < 7; i++) rd_chk(i, wm[i]);
        chk("taps", 32'h0000_03ff, {22'h0, tap});
    endtask : t_all_bits

    // Mask gating on bank two and the named taps that follow it
    task automatic t_mask;
        wr(off[0], 32'h0000_0000, 1'b0);
        rd_chk(0, 16'hfdff);
        wr(off[0], 32'h8401_0000, 1'b0);
        rd_chk(0, 16'h79fe);
        wr(off[0], 32'h0001_8401, 1'b0);
        rd_chk(0, 16'h79ff);
        wr(off[0], 32'h0200_0200, 1'b0);
        rd_chk(0, 16'h79ff);
        chk("taps", 32'h0000_00ff, {22'h0, tap});
    endtask : t_mask

    // Unmapped and misaligned places answer with an error and change nothing
    task automatic t_unmapped;
        logic [31:0] rd;
        logic        er;
        apb(1'b0, 12'h1dc, 32'h0000_0000, 1'b1, rd, er);
        chk("unmapped rdata", 32'h0000_0000, rd);
        chk("unmapped pslverr", 32'h0000_0001, {31'h0, er});
        apb(1'b0, 12'h1bc, 32'h0000_0000, 1'b1, rd, er);
        chk("below pslverr", 32'h0000_0001, {31'h0, er});
        wr(12'h1c2, 32'hffff_0000, 1'b1);
        wr(12'h1dc, 32'hffff_ffff, 1'b1);
        rd_chk(0, 16'h79ff);
    endtask : t_unmapped

    // Release by writing zero under a full mask
    task automatic t_clear;
        // An empty mask on bank eight must not clear it
        wr(off[6], 32'h0000_0000, 1'b0);
        rd_chk(6, 16'h7fff);
        for (int i = 1; i < 7; i++) wr(off[i], 32'hffff_0000, 1'b0);
        for (int i = 1; i < 7; i++) rd_chk(i, 16'h0000);
        chk("taps", 32'h0000_00c0, {22'h0, tap});
    endtask : t_clear

    // Reset in mid-run drops every request at once
    task automatic t_midrun_reset;
        wr(off[2], 32'hffff_ffff, 1'b0);
        rd_chk(2, 16'h71ad);
        presetn <= 1'b0;
        @(negedge pclk);
        for (int i = 0; i < 7; i++) chk("port in reset", 32'h0000_0000, {16'h0, rq[i]});
        chk("taps in reset", 32'h0000_0000, {22'h0, tap});
        chk("pready in reset", 32'h0000_0001, {31'h0, pready});
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 7; i++) rd_chk(i, 16'h0000);
    endtask : t_midrun_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset_values();
        t_all_bits();
        t_mask();
        t_unmapped();
        t_clear();
        t_midrun_reset();
        end_sim();
    end
endmodule : test_soft_reset_request_bank
